// *** tb/tb_vectored_interrupt_encoder.sv ***
// Purpose: Self-checking bench of the interrupt encoder
// Assumes: Watchdog timeout shortened to 50 cycles
// Notes: Slots 6-11 and 16-21 are level flags, the rest pulses
`default_nettype none
module tb_vectored_interrupt_encoder;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] exp_vec [22] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30, 8'h32, 8'h38,
        8'h3a, 8'h3c, 8'h3e, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h60, 8'h62, 8'h80, 8'h84};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [9:0] pls = 10'h000;
    logic [7:0] reg_addr, vector_q, v;
    logic [31:0] reg_wdata, reg_rdata_q, d;
    logic reg_wr, reg_rd, irq_q, device_reset_q;
    logic [11:0] lvl;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 clk_sys = ~clk_sys;
    vie_mcu u_vie_mcu (.clk_sys, .reg_rdata_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .lvl);
    vie_top #(.WDOG_TIMEOUT_CYC(32'h0000_0032)) u_vie_top (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .out_ep_done(pls[2:0]), .in_ep_done(pls[5:3]), .setup_overwrite_event(lvl[0]),
        .setup_received_flag(lvl[1]), .resume_event(lvl[2]), .suspend_event(lvl[3]), .bus_reset_event(lvl[4]),
        .wakeup_event(lvl[5]), .two_wire_done(pls[7:6]), .ctrl_in_token(pls[8]), .ctrl_out_token(pls[9]),
        .line_status_flag(lvl[6]), .modem_change_flag(lvl[7]), .receive_full_event(lvl[8]),
        .transmit_empty_event(lvl[9]), .dma1_done_flag(lvl[10]), .dma3_done_flag(lvl[11]), .vector_q, .irq_q,
        .device_reset_q);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic int li(input int s);
        return (s > 5 && s < 12) ? s - 6 : (s > 15) ? s - 10 : -1;
    endfunction
    task automatic fire(input int s);
        int p;
        p = (s < 6) ? s : s - 6;
        if (li(s) >= 0) u_vie_mcu.flag(li(s), 1'b1);
        else begin
            @(posedge clk_sys);
            pls[p] <= 1'b1;
            @(posedge clk_sys);
            pls[p] <= 1'b0;
        end
    endtask
    task automatic t_each();
        for (int s = 0; s < 22; s++) begin
            fire(s);
            tick(3);
            chk("vector", exp_vec[s], vector_q);
            u_vie_mcu.isr(li(s), v);
            chk("read vector", exp_vec[s], v);
            tick(3);
            chk("cleared", 8'h00, vector_q);
        end
    endtask
    task automatic t_prio();
        for (int s = 0; s < 22; s++) fire(s);
        for (int s = 21; s >= 0; s--) begin
            tick(3);
            chk("priority", exp_vec[s], vector_q);
            u_vie_mcu.isr(li(s), v);
        end
    endtask
    task automatic t_irq();
        u_vie_mcu.wr(8'h08, 32'h0000_0003);
        u_vie_mcu.wr(8'h0c, 32'h0000_0001);
        u_vie_mcu.rd(8'h0c, d);
        chk("enable readback", 32'h0000_0001, d);
        fire(21);
        tick(3);
        u_vie_mcu.wr(8'h00, 32'h0000_0000);
        tick(3);
        chk("reassert", 8'h84, vector_q);
        chk("irq", 1'b1, irq_q);
        u_vie_mcu.rd(8'h04, d);
        chk("status", 32'h0000_0003, d);
        u_vie_mcu.rd(8'h3c, d);
        chk("unmapped", 32'h0000_0000, d);
        u_vie_mcu.isr(11, v);
        u_vie_mcu.wr(8'h08, 32'h0000_0003);
        tick(2);
        chk("irq cleared", 1'b0, irq_q);
        u_vie_mcu.wr(8'h0c, 32'h0000_0000);
        fire(0);
        u_vie_mcu.rd(8'h04, d);
        chk("status new", 32'h0000_0001, d);
        chk("irq masked", 1'b0, irq_q);
        u_vie_mcu.isr(-1, v);
    endtask
    task automatic t_wdog();
        int n;
        u_vie_mcu.wr(8'h10, 32'h0000_0003);
        fire(5);
        repeat (4) begin
            tick(30);
            u_vie_mcu.wr(8'h10, 32'h0000_0003);
        end
        tick(0);
        chk("kicked", 1'b0, device_reset_q);
        n = 0;
        while (device_reset_q !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk("fired", 1'b1, device_reset_q);
        n = 0;
        while (device_reset_q === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("pulse cycles", 32'h0000_0010, 32'(n));
        chk("vector after", 8'h00, vector_q);
        u_vie_mcu.rd(8'h10, d);
        chk("watchdog back on", 32'h0000_0001, d);
        u_vie_mcu.rd(8'h14, d);
        chk("pending after", 32'h0000_0000, d);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        u_vie_mcu.rd(8'h10, d);
        chk("watchdog on", 32'h0000_0001, d);
        u_vie_mcu.wr(8'h10, 32'h0000_0000);
        t_each();
        t_prio();
        t_irq();
        t_wdog();
        results();
    end
    initial begin
        #30000;
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire

// *** tb/vie_mcu.sv ***
// Purpose: Firmware model that services vectors
// Assumes: Register port never waits
// Notes: Level flags are owned here so the service order can be kept
`default_nettype none
module vie_mcu (
    input wire logic clk_sys,
    input wire logic [31:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [11:0] lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, lvl} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
    task automatic flag(input int i, input logic v);
        @(posedge clk_sys);
        lvl[i] <= v;
    endtask
    // Flag first: a vector write while the flag stands re-arms the slot
    task automatic isr(input int i, output logic [7:0] v);
        logic [31:0] d;
        rd(8'h00, d);
        v = d[7:0];
        if (i >= 0) flag(i, 1'b0);
        wr(8'h00, 32'h0000_0000);
    endtask
endmodule
`default_nettype wire

// *** tb/vie_top_properties.sv ***
// Purpose: Port-level properties of the interrupt encoder
// Assumes: One clock, synchronous active-low reset
// Notes: Watchdog bounds keep a few cycles of slack
`default_nettype none
module vie_top_checker #(
    parameter logic [31:0] WDOG_TIMEOUT_CYC = 32'h0000_0032
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic [2:0] in_ep_done,
    input wire logic dma3_done_flag,
    input wire logic [7:0] vector_q,
    input wire logic irq_q,
    input wire logic device_reset_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] hi_q;
    logic [31:0] run_q;
    logic wr_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk_sys) begin
        hi_q <= device_reset_q ? hi_q + 5'h1 : 5'h0;
        run_q <= (!reset_n || device_reset_q) ? 32'h0 : run_q + 32'h1;
        wr_q <= reset_n && !device_reset_q && (wr_q || reg_wr);
    end
    AST_VEC_FORM: assert property (vector_q != 8'h00 |-> !vector_q[0] && vector_q[7:4] inside {[4'h1:4'h8]})
        else $error("bad vector byte");
    AST_RST_CLEAR: assert property (disable iff (1'b0) !reset_n |=> vector_q == 8'h00 && !irq_q && !device_reset_q)
        else $error("reset left state");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
        else $error("read data outside read");
    AST_EP_LATENCY: assert property (in_ep_done[0] && !reg_wr ##1 !reg_wr |=> vector_q >= 8'h22 || device_reset_q)
        else $error("endpoint vector late");
    AST_TOP_WINS: assert property (dma3_done_flag [*2] |=> vector_q == 8'h84 || device_reset_q)
        else $error("highest vector lost");
    AST_BLK_CLEAR: assert property (device_reset_q [*3] |-> vector_q == 8'h00 && !irq_q)
        else $error("state kept in watchdog reset");
    AST_PULSE_LEN: assert property ($fell(device_reset_q) |-> hi_q == 5'h10)
        else $error("reset pulse length");
    AST_WDOG_MIN: assert property ($rose(device_reset_q) |-> run_q >= WDOG_TIMEOUT_CYC - 32'h1)
        else $error("watchdog fired early");
    AST_WDOG_ON: assert property (!wr_q |-> run_q <= WDOG_TIMEOUT_CYC + 32'h3)
        else $error("watchdog not running");
    CV_WDOG: cover property ($rose(device_reset_q));
    CV_TOP: cover property (vector_q == 8'h84);
    CV_IRQ: cover property ($rose(irq_q));
endmodule
bind vie_top vie_top_checker #(.WDOG_TIMEOUT_CYC(WDOG_TIMEOUT_CYC)) u_vie_top_checker (.clk_sys, .reset_n,
    .reg_wr, .reg_rd, .reg_rdata_q, .in_ep_done, .dma3_done_flag, .vector_q, .irq_q, .device_reset_q);
`default_nettype wire

// *** verilog/vie_pkg.sv ***
// Purpose: Shared constants of the vectored interrupt encoder
// Assumes: 100 MHz core clock, 32-bit register port with byte addresses
// Notes: Source slots are ordered by ascending vector code
`default_nettype none
package vie_pkg;
    localparam int unsigned VIE_NSRC = 22;
    localparam int unsigned VIE_IDXW = 5;
    localparam int unsigned VIE_DW = 32;
    localparam int unsigned VIE_AW = 8;

    // Register byte addresses
    localparam logic [7:0] VIE_ADDR_VECTOR = 8'h00;
    localparam logic [7:0] VIE_ADDR_STATUS = 8'h04;
    localparam logic [7:0] VIE_ADDR_CLEAR = 8'h08;
    localparam logic [7:0] VIE_ADDR_ENABLE = 8'h0c;
    localparam logic [7:0] VIE_ADDR_WDOG = 8'h10;
    localparam logic [7:0] VIE_ADDR_PENDING = 8'h14;

    // Status / enable / clear layout
    localparam int unsigned VIE_NEVT = 2;
    localparam int unsigned VIE_EVT_NEW = 0;
    localparam int unsigned VIE_EVT_REASSERT = 1;
    localparam logic [1:0] VIE_EVT_RESET = 2'h0;
    localparam logic [1:0] VIE_ENABLE_RESET = 2'h0;

    // Watchdog control layout
    localparam int unsigned VIE_WDOG_EN_BIT = 0;
    localparam int unsigned VIE_WDOG_KICK_BIT = 1;

    // Vector byte layout: group in the high nibble, index doubled below
    localparam int unsigned VIE_GRP_LSB = 4;
    localparam logic [7:0] VIE_VEC_NONE = 8'h00;

    localparam logic [7:0] VIE_VEC_TABLE [VIE_NSRC] = '{
        8'h12, 8'h14, 8'h16,
        8'h22, 8'h24, 8'h26,
        8'h30, 8'h32, 8'h38, 8'h3a, 8'h3c, 8'h3e,
        8'h40, 8'h42, 8'h44, 8'h46,
        8'h50, 8'h52, 8'h60, 8'h62,
        8'h80, 8'h84
    };

    // Slots that follow a source flag level rather than a one-cycle event
    localparam logic [21:0] VIE_LEVEL_MASK = 22'h3f_0fc0;

    // Timing
    localparam int unsigned VIE_CLK_HZ = 100_000_000;
    localparam int unsigned VIE_WDOG_TIMEOUT_MS = 100;
    localparam int unsigned VIE_WDOG_TIMEOUT_CYC = VIE_WDOG_TIMEOUT_MS * (VIE_CLK_HZ / 1000);
    localparam int unsigned VIE_USB_DISCONNECT_MS = 200;
    localparam logic [4:0] VIE_WDOG_PULSE_CYC = 5'h10;
endpackage
`default_nettype wire

// *** verilog/vie_prio_enc.sv ***
// Purpose: Picks the highest pending slot
// Assumes: Slots are sorted by ascending vector code
// Notes: Combinational
`default_nettype none
module vie_prio_enc (
    vie_sel_if.enc sel
);
    always_comb begin
        sel.sel_valid = 1'b0;
        sel.sel_idx = '0;
        // Later slots carry larger vectors, so the last hit wins
        for (int i = 0; i < vie_pkg::VIE_NSRC; i++) begin
            if (sel.pending[i]) begin
                sel.sel_valid = 1'b1;
                sel.sel_idx = vie_pkg::VIE_IDXW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/vie_sel_if.sv ***
// Purpose: Carries pending slots to the encoder and the winner back
// Assumes: Single clock domain, purely combinational path
// Notes: No clocking block
`default_nettype none
interface vie_sel_if;
    logic [vie_pkg::VIE_NSRC-1:0] pending;
    logic sel_valid;
    logic [vie_pkg::VIE_IDXW-1:0] sel_idx;
    modport enc (input pending, output sel_valid, output sel_idx);
    modport top (output pending, input sel_valid, input sel_idx);
endinterface
`default_nettype wire

// *** verilog/vie_top.sv ***
// Purpose: Vectored interrupt encoder with watchdog full reset
// Assumes: Source inputs synchronous to clk_sys; register port never waits
// Notes: Level slots re-arm while their source flag stays high
//
// The placing of the registers and strobed register access are this design's own decisions.
`default_nettype none
module vie_top #(
    parameter logic [31:0] WDOG_TIMEOUT_CYC = 32'(vie_pkg::VIE_WDOG_TIMEOUT_CYC)
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    input wire logic [2:0] out_ep_done,
    input wire logic [2:0] in_ep_done,
    input wire logic setup_overwrite_event,
    input wire logic setup_received_flag,
    input wire logic resume_event,
    input wire logic suspend_event,
    input wire logic bus_reset_event,
    input wire logic wakeup_event,
    input wire logic [1:0] two_wire_done,
    input wire logic ctrl_in_token,
    input wire logic ctrl_out_token,
    input wire logic line_status_flag,
    input wire logic modem_change_flag,
    input wire logic receive_full_event,
    input wire logic transmit_empty_event,
    input wire logic dma1_done_flag,
    input wire logic dma3_done_flag,
    output logic [7:0] vector_q,
    output logic irq_q,
    output logic device_reset_q
);
    localparam int unsigned NSRC = vie_pkg::VIE_NSRC;
    localparam int unsigned NEVT = vie_pkg::VIE_NEVT;

    // Watchdog and the derived block reset

    logic wdog_enabled;
    logic wdog_fire;
    wire logic wdog_sel = (reg_addr == vie_pkg::VIE_ADDR_WDOG);
    wire logic wdog_wr = reg_wr && wdog_sel;

    vie_wdog #(
        .TIMEOUT_CYC(WDOG_TIMEOUT_CYC)
    ) u_wdog (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl_wr(wdog_wr),
        .ctl_enable(reg_wdata[vie_pkg::VIE_WDOG_EN_BIT]),
        .ctl_kick(reg_wdata[vie_pkg::VIE_WDOG_KICK_BIT]),
        .enabled_q(wdog_enabled),
        .fire_q(wdog_fire)
    );

    // Everything below except device_reset_q sees a watchdog expiry as a power-on reset
    wire logic blk_rst_n = reset_n && !wdog_fire;

    // Source slot request vector, ascending vector order

    logic [NSRC-1:0] src_req;
    assign src_req[2:0] = out_ep_done;
    assign src_req[5:3] = in_ep_done;
    assign src_req[6] = setup_overwrite_event;
    assign src_req[7] = setup_received_flag;
    assign src_req[8] = resume_event;
    assign src_req[9] = suspend_event;
    assign src_req[10] = bus_reset_event;
    assign src_req[11] = wakeup_event;
    assign src_req[13:12] = two_wire_done;
    assign src_req[14] = ctrl_in_token;
    assign src_req[15] = ctrl_out_token;
    assign src_req[16] = line_status_flag;
    assign src_req[17] = modem_change_flag;
    assign src_req[18] = receive_full_event;
    assign src_req[19] = transmit_empty_event;
    assign src_req[20] = dma1_done_flag;
    assign src_req[21] = dma3_done_flag;

    // Pending slots

    logic [NSRC-1:0] pending_q;
    logic [NSRC-1:0] pending_d;
    logic [vie_pkg::VIE_IDXW-1:0] shown_idx_q;
    logic shown_valid_q;

    vie_sel_if sel ();
    assign sel.pending = pending_q;

    vie_prio_enc u_enc (
        .sel(sel.enc)
    );

    // Clearing targets the slot shown in vector_q, not the live winner,
    // so a higher vector arriving in the cycle of the write is not lost
    wire logic vec_sel = (reg_addr == vie_pkg::VIE_ADDR_VECTOR);
    wire logic vec_clear = reg_wr && vec_sel && shown_valid_q;

    logic [NSRC-1:0] clear_mask;
    always_comb begin
        clear_mask = '0;
        if (vec_clear) begin
            clear_mask[shown_idx_q] = 1'b1;
        end
    end

    // A level slot whose flag is still high re-arms at once;
    // the set beats the clear in the same cycle
    wire logic [NSRC-1:0] src_set = src_req;
    assign pending_d = (pending_q & ~clear_mask) | src_set;

    // Vector for the current winner
    wire logic [7:0] win_vec = sel.sel_valid ? vie_pkg::VIE_VEC_TABLE[sel.sel_idx] : vie_pkg::VIE_VEC_NONE;

    always_ff @(posedge clk_sys) begin
        if (!blk_rst_n) begin
            pending_q <= '0;
            shown_idx_q <= '0;
            shown_valid_q <= 1'b0;
            vector_q <= vie_pkg::VIE_VEC_NONE;
        end else begin
            pending_q <= pending_d;
            shown_idx_q <= sel.sel_idx;
            shown_valid_q <= sel.sel_valid;
            vector_q <= win_vec;
        end
    end

    // Block events for the processor interrupt line

    wire logic [NSRC-1:0] new_req = src_set & ~pending_q;
    wire logic [NSRC-1:0] reassert = clear_mask & src_set & vie_pkg::VIE_LEVEL_MASK;
    logic [NEVT-1:0] evt_set;
    assign evt_set[vie_pkg::VIE_EVT_NEW] = |new_req;
    assign evt_set[vie_pkg::VIE_EVT_REASSERT] = |reassert;

    wire logic clear_sel = (reg_addr == vie_pkg::VIE_ADDR_CLEAR);
    wire logic enable_sel = (reg_addr == vie_pkg::VIE_ADDR_ENABLE);
    wire logic [NEVT-1:0] evt_clear = (reg_wr && clear_sel) ? reg_wdata[NEVT-1:0] : '0;

    logic [NEVT-1:0] status_q;
    logic [NEVT-1:0] enable_q;
    // Set beats clear so an event landing on a clear write survives
    wire logic [NEVT-1:0] status_d = (status_q & ~evt_clear) | evt_set;
    wire logic irq_d = |(status_d & enable_q);

    always_ff @(posedge clk_sys) begin
        if (!blk_rst_n) begin
            status_q <= vie_pkg::VIE_EVT_RESET;
            enable_q <= vie_pkg::VIE_ENABLE_RESET;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (reg_wr && enable_sel) begin
                enable_q <= reg_wdata[NEVT-1:0];
            end
            irq_q <= irq_d;
        end
    end

    // Reset output toward the rest of the device

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            device_reset_q <= 1'b0;
        end else begin
            device_reset_q <= wdog_fire;
        end
    end

    // Register read port

    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        unique case (reg_addr)
            vie_pkg::VIE_ADDR_VECTOR: rd_word[7:0] = vector_q;
            vie_pkg::VIE_ADDR_STATUS: rd_word[NEVT-1:0] = status_q;
            vie_pkg::VIE_ADDR_ENABLE: rd_word[NEVT-1:0] = enable_q;
            vie_pkg::VIE_ADDR_WDOG: rd_word[vie_pkg::VIE_WDOG_EN_BIT] = wdog_enabled;
            vie_pkg::VIE_ADDR_PENDING: rd_word[NSRC-1:0] = pending_q;
            default: rd_word = '0;
        endcase
    end

    // Data stand only in the cycle after the strobe; zero otherwise
    always_ff @(posedge clk_sys) begin
        if (!blk_rst_n) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_word : '0;
        end
    end
endmodule
`default_nettype wire

// *** verilog/vie_wdog.sv ***
// Purpose: Watchdog that forces a full block reset on expiry
// Assumes: reset_n is the power-on reset, synchronous, active low
// Notes: Fire pulse is held a fixed number of cycles, then all restarts
`default_nettype none
module vie_wdog #(
    parameter logic [31:0] TIMEOUT_CYC = 32'(vie_pkg::VIE_WDOG_TIMEOUT_CYC)
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ctl_wr,
    input wire logic ctl_enable,
    input wire logic ctl_kick,
    output logic enabled_q,
    output logic fire_q
);
    logic [31:0] count_q;
    logic [4:0] pulse_q;
    wire logic pulse_done = (pulse_q == vie_pkg::VIE_WDOG_PULSE_CYC - 5'h1);
    wire logic expired = (count_q == TIMEOUT_CYC - 32'h1);
    wire logic restart = (ctl_wr && ctl_kick) || !enabled_q;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            enabled_q <= 1'b1;
            count_q <= '0;
            fire_q <= 1'b0;
            pulse_q <= '0;
        end else if (fire_q) begin
            pulse_q <= pulse_q + 5'h1;
            if (pulse_done) begin
                // Comes back exactly as after power-on
                fire_q <= 1'b0;
                enabled_q <= 1'b1;
                count_q <= '0;
                pulse_q <= '0;
            end
        end else begin
            if (ctl_wr) begin
                enabled_q <= ctl_enable;
            end
            if (restart) begin
                count_q <= '0;
            end else if (expired) begin
                fire_q <= 1'b1;
                count_q <= '0;
            end else begin
                count_q <= count_q + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire
